/* File: hw/dcap_defines.vh */
// Constants shared by the debug control access port design files
`ifndef DCAP_DEFINES_VH
`define DCAP_DEFINES_VH

// =====================================================
// Debugger-side register offsets (byte addresses)
`define DCAP_OFS_SOFT_RESET      8'h00
`define DCAP_OFS_ERASE_TRIGGER   8'h04
`define DCAP_OFS_ERASE_PROGRESS  8'h08
`define DCAP_OFS_PROT_STATE      8'h0C
`define DCAP_OFS_GUARD_STATE     8'h18
`define DCAP_OFS_GUARD_KEY       8'h1C
`define DCAP_OFS_P2C_WORD        8'h20
`define DCAP_OFS_P2C_PENDING     8'h24
`define DCAP_OFS_C2P_WORD        8'h28
`define DCAP_OFS_C2P_PENDING     8'h2C
`define DCAP_OFS_IDENT           8'hFC

// =====================================================
// Processor-side register offsets (byte addresses)
`define DCAP_CPU_P2C_WORD        12'h400
`define DCAP_CPU_P2C_PENDING     12'h404
`define DCAP_CPU_C2P_WORD        12'h480
`define DCAP_CPU_C2P_PENDING     12'h484
`define DCAP_CPU_GUARD_LOCK      12'h500
`define DCAP_CPU_GUARD_KEY       12'h504

// =====================================================
// Field positions and values
`define DCAP_BIT_CMD             0
`define DCAP_BIT_PROT            0
`define DCAP_BIT_SECPROT         1
`define DCAP_WORD_WAITING        1'b1
`define DCAP_WORD_TAKEN          1'b0
`define DCAP_ZERO32              32'h0000_0000

// =====================================================
// Serial link: debug port addresses, select fields, answers
`define DCAP_DP_IDCODE           2'h0
`define DCAP_DP_SELECT           2'h2
`define DCAP_SEL_AP_HI           31
`define DCAP_SEL_AP_LO           24
`define DCAP_SEL_BANK_HI         7
`define DCAP_SEL_BANK_LO         4
`define DCAP_AP_CPU_BUS          8'h00
`define DCAP_AP_CONTROL          8'h04
`define DCAP_ACK_OK              3'h1
`define DCAP_ACK_FAULT           3'h4
`define DCAP_REQ_BITS            4'h7
`define DCAP_ACK_BITS            6'h03
`define DCAP_DATA_BITS           6'h20

`endif

/* File: hw/dcap_mbox.v */
// One mailbox direction: data word plus pending flag
`timescale 1ns/1ps
`default_nettype none
`include "dcap_defines.vh"

module dcap_mbox #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Sender side
	input wire put,
	input wire [WIDTH-1:0] put_word,
	// Receiver side
	input wire take,
	// State
	output reg [WIDTH-1:0] word_q,
	output reg pending_q
);

	// =====================================================
	// Word store; a put in the same cycle as a take keeps pending set
	always @(posedge ref_clk) begin
		if (srst) begin
			word_q <= {WIDTH{1'b0}};
			pending_q <= `DCAP_WORD_TAKEN;
		end else begin
			if (put) begin
				word_q <= put_word;
			end
			if (put) begin
				pending_q <= `DCAP_WORD_WAITING;
			end else if (take) begin
				pending_q <= `DCAP_WORD_TAKEN;
			end
		end
	end

endmodule // dcap_mbox

`default_nettype wire

/* File: hw/dcap_sync.v */
// Two flip-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module dcap_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Asynchronous side
	input wire [WIDTH-1:0] async_in,
	// Synchronised side
	output reg [WIDTH-1:0] sync_q
);

	reg [WIDTH-1:0] meta_q;

	// =====================================================
	// Capture stage, read only by the second stage
	always @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule // dcap_sync

`default_nettype wire

/* File: hw/dcap_top.v */
// Debug control access port: serial wire debug target plus control registers
//
// How it works
// - Control port answers even under port protection
// - Protection faults all processor bus port accesses
// - Reset register write pulses soft reset request
// - Erase trigger write starts full chip erase
// - Erase progress reads busy during whole erase
// - Protection stays until next reset after erase
// - Slave erase always erases application first
// - Erase guard after reset refuses debugger erase
// - Guard alone never blocks debugger flash writes
// - Guard affects only full erase, not access
// - Guard state readable at its status register
// - Both protection states shown in status register
// - Sender write sets both pending flags waiting
// - Receiver read sets both pending flags taken
// - Debugger word write marks word waiting
// - Debugger word read marks word taken
// - Matching nonzero keys from both start erase
// - Ports reopen on reset after keyed erase
// - Lock write blocks guard removal until reset
// - Debugger registers unreachable from the processor
// - Erase write disables reset register until reset
// - Identification register readable at top offset
// - Processor lock blocks processor key writes
`include "dcap_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module dcap_top #(
	parameter [31:0] DP_IDCODE = 32'h1234_5677,     // Arbitrary value
	parameter [31:0] AP_IDENT = 32'h0ABC_DEF1,      // Arbitrary value
	parameter SLAVE_PRESENT = 0
) (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Serial wire debug pins
	input wire swd_clk,
	input wire swd_io_in,
	output reg swd_io_out_q,
	output reg swd_io_oe_q,
	// Protection configuration from the user config area
	input wire cfg_port_protection,
	input wire cfg_secure_port_protection,
	input wire cfg_erase_guard,
	// Processor register port
	input wire cpu_wr,
	input wire cpu_rd,
	input wire [11:0] cpu_addr,
	input wire [31:0] cpu_wdata,
	output reg [31:0] cpu_rdata_q,
	// System control
	output reg soft_reset_req_q,
	output reg cpu_bus_access_port_en_q,
	// Erase engine handshake
	output reg erase_app_req_q,
	output reg erase_slave_req_q,
	input wire erase_done
);

	// =====================================================
	// Local states
	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_REQ = 6'b000010;
	localparam [5:0] ST_TRN = 6'b000100;
	localparam [5:0] ST_ACK = 6'b001000;
	localparam [5:0] ST_WR = 6'b010000;
	localparam [5:0] ST_RD = 6'b100000;
	localparam [2:0] ER_IDLE = 3'b001;
	localparam [2:0] ER_APP = 3'b010;
	localparam [2:0] ER_SLV = 3'b100;

	// =====================================================
	// Declarations
	wire [1:0] pin_s;
	reg clk_prev_q;
	wire clk_rise;
	wire sdi;
	reg [5:0] st_q;
	reg [5:0] cnt_q;
	reg [7:0] req_q;
	reg [2:0] ack_q;
	reg [32:0] shift_q;
	reg [31:0] select_q;
	reg dbg_wr_q;
	reg [7:0] dbg_addr_q;
	reg [31:0] dbg_wdata_q;
	reg dbg_take_c2p;
	wire req_ap;
	wire req_read;
	wire req_ok;
	wire [7:0] ap_addr;
	wire [7:0] ap_sel;
	wire cpu_ap_blocked;
	reg port_prot_q;
	reg sec_prot_q;
	reg guard_q;
	reg guard_lifted_q;
	reg reset_blocked_q;
	reg cpu_lock_q;
	reg [31:0] dbg_key_q;
	reg dbg_key_set_q;
	reg [31:0] cpu_key_q;
	reg cpu_key_set_q;
	reg [2:0] er_q;
	wire erase_busy;
	wire dbg_wr_reg;
	wire erase_cmd;
	wire key_match;
	wire erase_go;
	wire [31:0] p2c_word;
	wire p2c_pend;
	wire [31:0] c2p_word;
	wire c2p_pend;
	wire p2c_put;
	wire p2c_take;
	wire c2p_put;
	wire c2p_take;

	// =====================================================
	// Pin synchronisers
	dcap_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.async_in({swd_clk, swd_io_in}),
		.sync_q(pin_s)
	);

	assign sdi = pin_s[0];
	assign clk_rise = pin_s[1] & ~clk_prev_q;

	// Link clock edge finder
	always @(posedge ref_clk) begin
		if (srst) begin
			clk_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= pin_s[1];
		end
	end

	// =====================================================
	// Request decode
	assign req_ap = req_q[1];
	assign req_read = req_q[2];
	assign req_ok = (^req_q[4:1] == req_q[5]) && !req_q[6] && req_q[7];
	assign ap_sel = select_q[`DCAP_SEL_AP_HI:`DCAP_SEL_AP_LO];
	assign ap_addr = {select_q[`DCAP_SEL_BANK_HI:`DCAP_SEL_BANK_LO], req_q[4:3], 2'b00};
	assign cpu_ap_blocked = req_ap && (ap_sel == `DCAP_AP_CPU_BUS) && port_prot_q;

	// Read value of a debugger-side register
	function [31:0] dbg_read;
		input [7:0] addr;
		begin
			dbg_read = `DCAP_ZERO32;
			case (addr)
				`DCAP_OFS_ERASE_PROGRESS: dbg_read[`DCAP_BIT_CMD] = erase_busy;
				`DCAP_OFS_PROT_STATE: begin
					dbg_read[`DCAP_BIT_PROT] = port_prot_q;
					dbg_read[`DCAP_BIT_SECPROT] = sec_prot_q;
				end
				`DCAP_OFS_GUARD_STATE: dbg_read[`DCAP_BIT_CMD] = guard_q & ~guard_lifted_q;
				`DCAP_OFS_P2C_WORD: dbg_read = p2c_word;
				`DCAP_OFS_P2C_PENDING: dbg_read[`DCAP_BIT_CMD] = p2c_pend;
				`DCAP_OFS_C2P_WORD: dbg_read = c2p_word;
				`DCAP_OFS_C2P_PENDING: dbg_read[`DCAP_BIT_CMD] = c2p_pend;
				`DCAP_OFS_IDENT: dbg_read = AP_IDENT;
				default: dbg_read = `DCAP_ZERO32;
			endcase
		end
	endfunction

	// =====================================================
	// Serial wire target state machine, stepped on link clock rises
	always @(posedge ref_clk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			cnt_q <= 6'h00;
			req_q <= 8'h00;
			ack_q <= `DCAP_ACK_OK;
			shift_q <= 33'h0_0000_0000;
			select_q <= `DCAP_ZERO32;
			swd_io_out_q <= 1'b0;
			swd_io_oe_q <= 1'b0;
			dbg_wr_q <= 1'b0;
			dbg_addr_q <= 8'h00;
			dbg_wdata_q <= `DCAP_ZERO32;
			dbg_take_c2p <= 1'b0;
		end else begin
			dbg_wr_q <= 1'b0;
			dbg_take_c2p <= 1'b0;
			if (clk_rise) begin
				case (st_q)
					ST_IDLE: begin
						if (sdi) begin
							req_q <= 8'h01;
							cnt_q <= 6'h01;
							st_q <= ST_REQ;
						end
					end
					ST_REQ: begin
						req_q[cnt_q[2:0]] <= sdi;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q[3:0] == `DCAP_REQ_BITS) begin
							st_q <= ST_TRN;
						end
					end
					ST_TRN: begin
						if (req_ok) begin
							// Control port is never gated by protection
							ack_q <= cpu_ap_blocked ? `DCAP_ACK_FAULT : `DCAP_ACK_OK;
							swd_io_out_q <= cpu_ap_blocked ? 1'b0 : 1'b1;
							swd_io_oe_q <= 1'b1;
							cnt_q <= 6'h01;
							st_q <= ST_ACK;
						end else begin
							st_q <= ST_IDLE;
						end
					end
					ST_ACK: begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q != `DCAP_ACK_BITS) begin
							swd_io_out_q <= ack_q[cnt_q[1:0]];
						end else if (ack_q != `DCAP_ACK_OK) begin
							swd_io_oe_q <= 1'b0;
							st_q <= ST_IDLE;
						end else if (req_read) begin
							// Load read data and apply read side effects
							if (!req_ap) begin
								shift_q[31:0] <= (req_q[4:3] == `DCAP_DP_IDCODE) ? DP_IDCODE
									: `DCAP_ZERO32;
							end else if (ap_sel == `DCAP_AP_CONTROL) begin
								shift_q[31:0] <= dbg_read(ap_addr);
								dbg_take_c2p <= (ap_addr == `DCAP_OFS_C2P_WORD);
							end else begin
								shift_q[31:0] <= `DCAP_ZERO32;
							end
							cnt_q <= 6'h00;
							st_q <= ST_RD;
						end else begin
							swd_io_oe_q <= 1'b0;
							cnt_q <= 6'h00;
							st_q <= ST_WR;
						end
					end
					ST_RD: begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q < `DCAP_DATA_BITS) begin
							swd_io_out_q <= shift_q[cnt_q[4:0]];
						end else if (cnt_q == `DCAP_DATA_BITS) begin
							swd_io_out_q <= ^shift_q[31:0];
						end else begin
							swd_io_oe_q <= 1'b0;
							st_q <= ST_IDLE;
						end
					end
					ST_WR: begin
						shift_q[cnt_q] <= sdi;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == `DCAP_DATA_BITS) begin
							st_q <= ST_IDLE;
							if ((^shift_q[31:0]) == sdi) begin
								if (!req_ap && req_q[4:3] == `DCAP_DP_SELECT) begin
									select_q <= shift_q[31:0];
								end
								dbg_wr_q <= req_ap && (ap_sel == `DCAP_AP_CONTROL);
								dbg_addr_q <= ap_addr;
								dbg_wdata_q <= shift_q[31:0];
							end
						end
					end
					default: begin
						swd_io_oe_q <= 1'b0;
						st_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// =====================================================
	// Mailboxes in both directions
	assign p2c_put = dbg_wr_q && (dbg_addr_q == `DCAP_OFS_P2C_WORD);
	assign p2c_take = cpu_rd && (cpu_addr == `DCAP_CPU_P2C_WORD);
	assign c2p_put = cpu_wr && (cpu_addr == `DCAP_CPU_C2P_WORD);
	assign c2p_take = dbg_take_c2p;

	dcap_mbox #(
		.WIDTH(32)
	) u_p2c (
		.ref_clk(ref_clk),
		.srst(srst),
		.put(p2c_put),
		.put_word(dbg_wdata_q),
		.take(p2c_take),
		.word_q(p2c_word),
		.pending_q(p2c_pend)
	);

	dcap_mbox #(
		.WIDTH(32)
	) u_c2p (
		.ref_clk(ref_clk),
		.srst(srst),
		.put(c2p_put),
		.put_word(cpu_wdata),
		.take(c2p_take),
		.word_q(c2p_word),
		.pending_q(c2p_pend)
	);

	// =====================================================
	// Erase triggers and key matching
	assign dbg_wr_reg = dbg_wr_q;
	assign erase_busy = !er_q[0];
	assign erase_cmd = dbg_wr_reg && (dbg_addr_q == `DCAP_OFS_ERASE_TRIGGER)
		&& dbg_wdata_q[`DCAP_BIT_CMD];
	assign key_match = guard_q && !guard_lifted_q && !cpu_lock_q
		&& dbg_key_set_q && cpu_key_set_q && (dbg_key_q == cpu_key_q);
	assign erase_go = (erase_cmd && !(guard_q && !guard_lifted_q)) || key_match;

	// Protection, guard and key state; configuration taken while in reset
	always @(posedge ref_clk) begin
		if (srst) begin
			port_prot_q <= cfg_port_protection;
			sec_prot_q <= cfg_secure_port_protection;
			guard_q <= cfg_erase_guard;
			guard_lifted_q <= 1'b0;
			reset_blocked_q <= 1'b0;
			cpu_lock_q <= 1'b0;
			dbg_key_q <= `DCAP_ZERO32;
			dbg_key_set_q <= 1'b0;
			cpu_key_q <= `DCAP_ZERO32;
			cpu_key_set_q <= 1'b0;
			soft_reset_req_q <= 1'b0;
			cpu_bus_access_port_en_q <= 1'b0;
		end else begin
			cpu_bus_access_port_en_q <= !port_prot_q;
			soft_reset_req_q <= dbg_wr_reg && (dbg_addr_q == `DCAP_OFS_SOFT_RESET)
				&& dbg_wdata_q[`DCAP_BIT_CMD] && !reset_blocked_q && !erase_cmd;
			if (erase_cmd) begin
				reset_blocked_q <= 1'b1;
			end
			if (cpu_wr && cpu_addr == `DCAP_CPU_GUARD_LOCK) begin
				cpu_lock_q <= 1'b1;
			end
			if (dbg_wr_reg && dbg_addr_q == `DCAP_OFS_GUARD_KEY) begin
				dbg_key_q <= dbg_wdata_q;
				dbg_key_set_q <= (dbg_wdata_q != `DCAP_ZERO32);
			end
			if (cpu_wr && cpu_addr == `DCAP_CPU_GUARD_KEY && !cpu_lock_q) begin
				cpu_key_q <= cpu_wdata;
				cpu_key_set_q <= (cpu_wdata != `DCAP_ZERO32);
			end
			if (key_match) begin
				guard_lifted_q <= 1'b1;
				dbg_key_set_q <= 1'b0;
				cpu_key_set_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// Erase sequencer: application first, then the slave when SLAVE_PRESENT is nonzero
	always @(posedge ref_clk) begin
		if (srst) begin
			er_q <= ER_IDLE;
			erase_app_req_q <= 1'b0;
			erase_slave_req_q <= 1'b0;
		end else begin
			case (er_q)
				ER_IDLE: begin
					if (erase_go) begin
						er_q <= ER_APP;
						erase_app_req_q <= 1'b1;
					end
				end
				ER_APP: begin
					if (erase_done) begin
						erase_app_req_q <= 1'b0;
						if (SLAVE_PRESENT != 0) begin
							er_q <= ER_SLV;
							erase_slave_req_q <= 1'b1;
						end else begin
							er_q <= ER_IDLE;
						end
					end
				end
				ER_SLV: begin
					if (erase_done) begin
						erase_slave_req_q <= 1'b0;
						er_q <= ER_IDLE;
					end
				end
				default: begin
					er_q <= ER_IDLE;
					erase_app_req_q <= 1'b0;
					erase_slave_req_q <= 1'b0;
				end
			endcase
		end
	end

	// =====================================================
	// Processor register reads; debugger-only offsets are absent here
	always @(posedge ref_clk) begin
		if (srst) begin
			cpu_rdata_q <= `DCAP_ZERO32;
		end else if (cpu_rd) begin
			case (cpu_addr)
				`DCAP_CPU_P2C_WORD: cpu_rdata_q <= p2c_word;
				`DCAP_CPU_P2C_PENDING: cpu_rdata_q <= {31'h0000_0000, p2c_pend};
				`DCAP_CPU_C2P_WORD: cpu_rdata_q <= c2p_word;
				`DCAP_CPU_C2P_PENDING: cpu_rdata_q <= {31'h0000_0000, c2p_pend};
				`DCAP_CPU_GUARD_LOCK: cpu_rdata_q <= {31'h0000_0000, cpu_lock_q};
				default: cpu_rdata_q <= `DCAP_ZERO32;
			endcase
		end
	end

endmodule // dcap_top

`default_nettype wire

/* File: tb/dcap_probe.sv */
// Behavioural debug probe on the serial wire debug link
`timescale 1ns/1ps
`default_nettype none
`include "dcap_defines.vh"

module dcap_probe (
	// Link pins
	output logic swd_clk,
	output logic drv,
	output logic drv_oe,
	// Resolved line level
	input wire logic swd_wire
);
	// =========================================
	// Link sequencing
	// Clock parked low and line released between frames
	initial begin
		swd_clk = 1'b0;
		drv = 1'b0;
		drv_oe = 1'b0;
	end

	// One link clock: line set while low, then rise and fall
	task automatic cyc(input logic oe, input logic v);
		drv_oe = oe;
		drv = v;
		#62.5 swd_clk = 1'b1;
		#62.5 swd_clk = 1'b0;
	endtask

	// Whole frame, LSB first; device bits read half a period after each rise
	task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a,
		input logic [31:0] wd, output logic [2:0] ack, output logic [31:0] rd);
		logic [7:0] rq;
		rq = {2'b10, ^{ap, rnw, a}, a, rnw, ap, 1'b1};
		#1.3;
		for (int i = 0; i < 8; i++) cyc(1'b1, rq[i]);
		for (int i = 0; i < 3; i++) begin
			cyc(1'b0, 1'b0);
			ack[i] = swd_wire;
		end
		// Device idles one cycle after the answer, then data bits and parity
		for (int i = 0; i < 34 && ack == `DCAP_ACK_OK && rnw; i++) begin
			cyc(1'b0, 1'b0);
			if (i > 0 && i < 33) rd[i - 1] = swd_wire;
		end
		// Turnaround, then write data with even parity, then idle low
		cyc(1'b0, 1'b0);
		for (int i = 0; i < 33 && ack == `DCAP_ACK_OK && !rnw; i++) cyc(1'b1, i < 32 ? wd[i] : ^wd);
		cyc(1'b1, 1'b0);
		cyc(1'b1, 1'b0);
		drv_oe = 1'b0;
	endtask
endmodule // dcap_probe
`default_nettype wire

/* File: tb/dcap_props.sv */
// Assertion checker for the debug control access port top level
`timescale 1ns/1ps
`default_nettype none
`include "dcap_defines.vh"

module dcap_props #(
	parameter SLAVE_PRESENT = 0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Link pins
	input wire logic swd_clk,
	input wire logic swd_io_in,
	input wire logic swd_io_out_q,
	input wire logic swd_io_oe_q,
	// Configuration
	input wire logic cfg_port_protection,
	input wire logic cfg_secure_port_protection,
	input wire logic cfg_erase_guard,
	// Processor port
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [11:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	input wire logic [31:0] cpu_rdata_q,
	// System control and erase
	input wire logic soft_reset_req_q,
	input wire logic cpu_bus_access_port_en_q,
	input wire logic erase_app_req_q,
	input wire logic erase_slave_req_q,
	input wire logic erase_done
);
	// =========================================
	// Helper logic
	logic prot_cap_q;

	// Protection level as seen on the last reset edge
	always @(posedge ref_clk) begin
		if (srst) prot_cap_q <= cfg_port_protection;
	end

	// =========================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// Erase steps
	sequence s_app_ends;
		(SLAVE_PRESENT != 0) && erase_app_req_q && erase_done;
	endsequence
	sequence s_slave_runs;
		!erase_app_req_q && erase_slave_req_q;
	endsequence
	// Processor mailbox steps
	sequence s_c2p_put_peek;
		(cpu_wr && cpu_addr == `DCAP_CPU_C2P_WORD) ##1 (cpu_rd && cpu_addr == `DCAP_CPU_C2P_PENDING);
	endsequence
	sequence s_p2c_take_peek;
		(cpu_rd && cpu_addr == `DCAP_CPU_P2C_WORD) ##1 (cpu_rd && cpu_addr == `DCAP_CPU_P2C_PENDING);
	endsequence

	property p_slave_after_app;
		s_app_ends |=> s_slave_runs;
	endproperty
	property p_slave_needs_app;
		$rose(erase_slave_req_q) |-> $past(erase_app_req_q) && $past(erase_done);
	endproperty
	property p_app_holds;
		erase_app_req_q && !erase_done |=> erase_app_req_q;
	endproperty
	property p_slave_drops;
		erase_slave_req_q && erase_done |=> !erase_slave_req_q && !erase_app_req_q;
	endproperty
	property p_soft_pulse;
		soft_reset_req_q |=> !soft_reset_req_q;
	endproperty
	property p_prot_held;
		!$past(srst) && !$past(srst, 2) |-> cpu_bus_access_port_en_q == !prot_cap_q;
	endproperty
	property p_cpu_unmapped;
		cpu_rd && cpu_addr < 12'h400 |=> cpu_rdata_q == 32'h0000_0000;
	endproperty
	property p_c2p_flag;
		s_c2p_put_peek |=> cpu_rdata_q[0];
	endproperty
	property p_p2c_taken;
		s_p2c_take_peek |=> !cpu_rdata_q[0];
	endproperty

	a_slave_after_app: assert property (p_slave_after_app)
		else $error("slave erase did not follow application erase");
	a_slave_needs_app: assert property (p_slave_needs_app)
		else $error("slave erase began without finished application erase");
	a_app_holds: assert property (p_app_holds)
		else $error("application erase request dropped early");
	a_slave_drops: assert property (p_slave_drops)
		else $error("erase request stayed after final step");
	a_soft_pulse: assert property (p_soft_pulse)
		else $error("soft reset request longer than one cycle");
	a_prot_held: assert property (p_prot_held)
		else $error("bus port enable disagrees with latched protection");
	a_cpu_unmapped: assert property (p_cpu_unmapped)
		else $error("processor read of probe-only space returned data");
	a_c2p_flag: assert property (p_c2p_flag)
		else $error("processor send flag not waiting after write");
	a_p2c_taken: assert property (p_p2c_taken)
		else $error("processor receive flag not taken after read");
endmodule // dcap_props

bind dcap_top dcap_props #(.SLAVE_PRESENT(SLAVE_PRESENT)) dcap_props_i (
	.ref_clk(ref_clk), .srst(srst), .swd_clk(swd_clk), .swd_io_in(swd_io_in),
	.swd_io_out_q(swd_io_out_q), .swd_io_oe_q(swd_io_oe_q),
	.cfg_port_protection(cfg_port_protection),
	.cfg_secure_port_protection(cfg_secure_port_protection),
	.cfg_erase_guard(cfg_erase_guard), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
	.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
	.soft_reset_req_q(soft_reset_req_q), .cpu_bus_access_port_en_q(cpu_bus_access_port_en_q),
	.erase_app_req_q(erase_app_req_q), .erase_slave_req_q(erase_slave_req_q),
	.erase_done(erase_done));
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the debug control access port
`timescale 1ns/1ps
`default_nettype none
`include "dcap_defines.vh"

module tb_top;
	localparam logic [31:0] IDC = 32'h2468_ACE1; // Arbitrary value
	localparam logic [31:0] IDA = 32'h1357_9BDF; // Arbitrary value
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic cfg_p = 1'b0, cfg_s = 1'b0, cfg_g = 1'b0;
	logic cpu_wr = 1'b0, cpu_rd = 1'b0, erase_done = 1'b0;
	logic [11:0] cpu_addr = 12'h000;
	logic [31:0] cpu_wdata = 32'h0, cpu_rdata_q, rd, w, cur_sel;
	logic [2:0] ack;
	wire swd_clk, drv, drv_oe, io_out, io_oe, swd_wire, rst_req, en_q, app_q, slv_q;
	int error_cnt = 0, samples_checked = 0, cycles = 0, rst_cnt = 0, app_cnt = 0, ecnt = 0;

	// Line level: device, else probe, else pull-up
	assign swd_wire = (io_oe === 1'b1) ? io_out : (drv_oe ? drv : 1'b1);
	always #4 ref_clk = ~ref_clk;

	dcap_top #(.DP_IDCODE(IDC), .AP_IDENT(IDA), .SLAVE_PRESENT(1)) dcap_top_i (
		.ref_clk(ref_clk), .srst(srst), .swd_clk(swd_clk), .swd_io_in(swd_wire),
		.swd_io_out_q(io_out), .swd_io_oe_q(io_oe), .cfg_port_protection(cfg_p),
		.cfg_secure_port_protection(cfg_s), .cfg_erase_guard(cfg_g), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
		.soft_reset_req_q(rst_req), .cpu_bus_access_port_en_q(en_q), .erase_app_req_q(app_q),
		.erase_slave_req_q(slv_q), .erase_done(erase_done));
	dcap_probe dcap_probe_i (.swd_clk(swd_clk), .drv(drv), .drv_oe(drv_oe), .swd_wire(swd_wire));

	// =========================================
	// Erase engine stand-in, pulse counters and hang limit
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		erase_done <= 1'b0;
		if ((app_q | slv_q) && !erase_done) ecnt <= ecnt + 1;
		if (ecnt == 1500) begin
			erase_done <= 1'b1;
			ecnt <= 0;
		end
		if (rst_req === 1'b1) rst_cnt <= rst_cnt + 1;
		if ($rose(app_q)) app_cnt <= app_cnt + 1;
		if (cycles == 90000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// =========================================
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic rst(input logic p, input logic s, input logic g);
		@(posedge ref_clk);
		srst <= 1'b1;
		cfg_p <= p;
		cfg_s <= s;
		cfg_g <= g;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		cur_sel = 32'hFFFF_FFFF;
	endtask

	// Processor access; result sampled half a cycle after the taking edge
	task automatic cpu(input logic wr, input logic [11:0] a, input logic [31:0] d);
		cpu_wr <= wr;
		cpu_rd <= !wr;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(posedge ref_clk);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		@(negedge ref_clk);
		rd = cpu_rdata_q;
	endtask

	// Access port transfer; bank select rewritten only when it changes
	task automatic ap(input logic rnw, input logic [7:0] ofs, input logic [31:0] wd,
		input logic [7:0] sel_ap);
		logic [31:0] sel;
		sel = {sel_ap, 16'h0000, ofs[7:4], 4'h0};
		@(posedge ref_clk);
		if (sel !== cur_sel) begin
			dcap_probe_i.xfer(1'b0, 1'b0, 2'b10, sel, ack, rd);
			cur_sel = sel;
		end
		@(posedge ref_clk);
		dcap_probe_i.xfer(1'b1, rnw, ofs[3:2], wd, ack, rd);
	endtask

	task automatic apr(input string nm, input logic [7:0] ofs, input logic [31:0] m,
		input logic [31:0] e);
		ap(1'b1, ofs, 32'h0, `DCAP_AP_CONTROL);
		check(nm, rd & m, e);
	endtask

	task automatic cpr(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		cpu(1'b0, a, 32'h0);
		check(nm, rd & m, e);
	endtask

	task automatic wait_erase();
		for (int n = 0; n < 5000 && (app_q !== 1'b0 || slv_q !== 1'b0); n++) @(posedge ref_clk);
	endtask

	// =========================================
	// Main sequence
	initial begin
		w = $urandom(24);
		rst(1'b1, 1'b1, 1'b0);
		dcap_probe_i.xfer(1'b0, 1'b1, 2'b00, 32'h0, ack, rd);
		check("link ident", rd, IDC);
		apr("port ident", 8'hFC, 32'hFFFF_FFFF, IDA);
		apr("prot state", 8'h0C, 32'h3, 32'h3);
		apr("guard state", 8'h18, 32'h1, 32'h0);
		check("bus port en", en_q, 32'h0);
		ap(1'b1, 8'h00, 32'h0, `DCAP_AP_CPU_BUS);
		check("bus port ack", ack, `DCAP_ACK_FAULT);
		w = 32'h30 + 4 * $urandom_range(0, 50);
		ap(1'b0, w[7:0], 32'hFFFF_FFFF, `DCAP_AP_CONTROL);
		apr("unlisted", w[7:0], 32'hFFFF_FFFF, 32'h0);
		w = $urandom_range(0, 32'h3FF);
		cpr("cpu view", w[11:0], 32'hFFFF_FFFF, 32'h0);
		$display("access test done");
		repeat (2) begin
			w = $urandom;
			ap(1'b0, 8'h20, w, `DCAP_AP_CONTROL);
			apr("probe send flag", 8'h24, 32'h1, 32'h1);
			cpr("cpu recv flag", `DCAP_CPU_P2C_PENDING, 32'h1, 32'h1);
			cpr("cpu word", `DCAP_CPU_P2C_WORD, 32'hFFFF_FFFF, w);
			cpr("cpu recv cleared", `DCAP_CPU_P2C_PENDING, 32'h1, 32'h0);
			apr("probe send cleared", 8'h24, 32'h1, 32'h0);
			w = $urandom;
			cpu(1'b1, `DCAP_CPU_C2P_WORD, w);
			cpr("cpu send flag", `DCAP_CPU_C2P_PENDING, 32'h1, 32'h1);
			apr("probe recv flag", 8'h2C, 32'h1, 32'h1);
			apr("probe word", 8'h28, 32'hFFFF_FFFF, w);
			apr("probe recv cleared", 8'h2C, 32'h1, 32'h0);
			cpr("cpu send cleared", `DCAP_CPU_C2P_PENDING, 32'h1, 32'h0);
		end
		$display("mailbox test done");
		ap(1'b0, 8'h00, 32'h1, `DCAP_AP_CONTROL);
		check("soft resets", rst_cnt, 32'h1);
		ap(1'b0, 8'h04, 32'h1, `DCAP_AP_CONTROL);
		apr("erase busy", 8'h08, 32'h1, 32'h1);
		wait_erase();
		apr("erase idle", 8'h08, 32'h1, 32'h0);
		apr("prot after erase", 8'h0C, 32'h3, 32'h3);
		ap(1'b0, 8'h00, 32'h1, `DCAP_AP_CONTROL);
		check("reset locked out", rst_cnt, 32'h1);
		$display("erase test done");
		rst(1'b0, 1'b0, 1'b1);
		check("bus port en", en_q, 32'h1);
		apr("guard state", 8'h18, 32'h1, 32'h1);
		ap(1'b0, 8'h04, 32'h1, `DCAP_AP_CONTROL);
		check("guarded erase", app_cnt, 32'h1);
		ap(1'b1, 8'h00, 32'h0, `DCAP_AP_CPU_BUS);
		check("bus port ack", ack, `DCAP_ACK_OK);
		w = $urandom | 32'h1;
		cpu(1'b1, `DCAP_CPU_GUARD_LOCK, 32'h1);
		cpu(1'b1, `DCAP_CPU_GUARD_KEY, w);
		ap(1'b0, 8'h1C, w, `DCAP_AP_CONTROL);
		check("locked key", app_cnt, 32'h1);
		rst(1'b0, 1'b0, 1'b1);
		ap(1'b0, 8'h1C, w, `DCAP_AP_CONTROL);
		cpu(1'b1, `DCAP_CPU_GUARD_KEY, 32'h0);
		repeat (8) @(posedge ref_clk);
		check("zero key", app_cnt, 32'h1);
		cpu(1'b1, `DCAP_CPU_GUARD_KEY, w);
		repeat (8) @(posedge ref_clk);
		check("key erase", app_cnt, 32'h2);
		wait_erase();
		apr("guard lifted", 8'h18, 32'h1, 32'h0);
		$display("guard test done");
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
